// ==== hw/hmc_pkg.sv ====
// Constants of the Hall measurement configuration and trigger block
package hmc_pkg;
   localparam logic [7:0]  CFG_ADDR       = 8'h1C;
   localparam logic [15:0] CFG_RESET      = 16'h0030;
   localparam int          FILTER_LSB     = 0;
   localparam int          GAIN_LSB       = 3;
   localparam int          PIN_TRIG_BIT   = 7;
   localparam int          BUTTON_BIT     = 8;
   localparam int          FIELD_OSR_LSB  = 9;
   localparam int          THERM_OSR_LSB  = 11;
   localparam int          WAKE_BIT       = 13;
   localparam int          PLANE_LSB      = 14;
   localparam logic [11:0] OSR_BASE       = 12'h020;
   localparam logic [7:0]  FILTER_ADDEND  = 8'h02;
   localparam logic [11:0] CONV_OVERHEAD  = 12'h045;
   localparam int          CLK_MHZ        = 200;
   localparam int          TIME_UNIT_NS   = 1000;
   localparam int          CLK_PERIOD_NS  = TIME_UNIT_NS / CLK_MHZ;
   localparam int          CYC_PER_US     = TIME_UNIT_NS / CLK_PERIOD_NS;
   localparam int          TIMER_W        = 24;
endpackage : hmc_pkg

// ==== hw/hmc_top.sv ====
// Measurement configuration register, conversion timer and trigger pin
//
// Operation
// - Bits 2:0 hold the filter code; it enters the per-axis sample count.
// - Trigger enabled, button off: pin high pulse starts one single conversion.
// - Button bit enables detection; setting it alone never drives the pin.
// - Button mode drives pin only after command when field reaches base.
// - Axis sample count is two to the oversample code times filter term.
// - One axis conversion lasts sample count plus 69 microseconds.
`timescale 1ns/1ps
`default_nettype none
module hmc_top #(
   parameter int CYC_PER_US = hmc_pkg::CYC_PER_US,
   parameter int FIELD_W    = 16
) (
   input  wire  logic               clk_i,
   input  wire  logic               rst_i,
   input  wire  logic [7:0]         reg_addr_i,
   input  wire  logic [15:0]        reg_wdata_i,
   input  wire  logic               reg_we_i,
   input  wire  logic               reg_re_i,
   output logic       [15:0]        reg_rdata_o,
   input  wire  logic               meas_cmd_i,
   input  wire  logic [FIELD_W-1:0] plane_field_i,
   input  wire  logic [FIELD_W-1:0] base_value_i,
   input  wire  logic               trigger_button_pin_i,
   output logic                     trigger_button_pin_o,
   output logic                     trigger_button_pin_oe_o,
   output logic                     conv_busy_o,
   output logic                     conv_done_o,
   output logic       [11:0]        adc_samples_o,
   output logic       [11:0]        field_osr_samples_o,
   output logic       [11:0]        thermal_osr_samples_o
);
   logic [15:0]                  cfg;
   logic [2:0]                   pin_sync;
   logic                         pin_level;
   logic                         button_armed;
   logic [hmc_pkg::TIMER_W-1:0]  timer;
   logic [hmc_pkg::TIMER_W-1:0]  conv_len;
   logic [hmc_pkg::TIMER_W-1:0]  conv_len_exp;

   wire                          cfg_sel;
   wire  [2:0]                   filter_depth_code;
   wire  [1:0]                   field_oversample_code;
   wire  [1:0]                   thermal_oversample_code;
   wire                          pin_trigger_enable;
   wire                          button_detect_select;
   wire                          pin_rise;
   wire                          pin_start;
   wire                          start;
   wire                          conv_end;
   wire  [7:0]                   filter_term;
   wire  [11:0]                  next_adc;
   wire  [hmc_pkg::TIMER_W-1:0]  next_timer_load;
   wire                          field_reached;

   assign cfg_sel                 = (reg_addr_i == hmc_pkg::CFG_ADDR);
   assign filter_depth_code       = cfg[hmc_pkg::FILTER_LSB +: 3];
   assign field_oversample_code   = cfg[hmc_pkg::FIELD_OSR_LSB +: 2];
   assign thermal_oversample_code = cfg[hmc_pkg::THERM_OSR_LSB +: 2];
   assign pin_trigger_enable      = cfg[hmc_pkg::PIN_TRIG_BIT];
   assign button_detect_select    = cfg[hmc_pkg::BUTTON_BIT];

   // Second and third stages must agree, filters single-cycle glitches
   assign pin_rise  = (pin_sync[1] == pin_sync[2]) && pin_sync[2]
                      && !pin_level;
   // pin pulse acts as single command
   assign pin_start = pin_rise && pin_trigger_enable && !button_detect_select;
   // Starts during a running conversion are dropped, not queued
   assign start     = (meas_cmd_i || pin_start) && !conv_busy_o;
   assign conv_end  = conv_busy_o && (timer == 1);

   // samples = 2^osr * (2^filter + 2)
   assign filter_term = (8'h01 << filter_depth_code) + hmc_pkg::FILTER_ADDEND;
   assign next_adc    = {4'h0, filter_term} << field_oversample_code;
   assign next_timer_load = hmc_pkg::TIMER_W'((adc_samples_o
                            + hmc_pkg::CONV_OVERHEAD) * CYC_PER_US);
   assign field_reached   = (plane_field_i >= base_value_i);

   // upper bits stored as plain read-write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= hmc_pkg::CFG_RESET;
      end else if (reg_we_i && cfg_sel) begin
         cfg <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_re_i) begin
         reg_rdata_o <= cfg_sel ? cfg : 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_sync  <= 3'h0;
         pin_level <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], trigger_button_pin_i};
         if (pin_sync[1] == pin_sync[2]) begin
            pin_level <= pin_sync[2];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adc_samples_o         <= 12'h000;
         field_osr_samples_o   <= 12'h000;
         thermal_osr_samples_o <= 12'h000;
      end else begin
         adc_samples_o         <= next_adc;
         field_osr_samples_o   <= hmc_pkg::OSR_BASE << field_oversample_code;
         thermal_osr_samples_o <= hmc_pkg::OSR_BASE << thermal_oversample_code;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer       <= '0;
         conv_busy_o <= 1'b0;
         conv_done_o <= 1'b0;
      end else begin
         conv_done_o <= conv_end;
         if (start) begin
            timer       <= next_timer_load;
            conv_busy_o <= 1'b1;
         end else if (conv_busy_o) begin
            timer       <= timer - 1'b1;
            conv_busy_o <= !conv_end;
         end
      end
   end

   // armed only by a host command, output at conversion end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         button_armed            <= 1'b0;
         trigger_button_pin_o    <= 1'b0;
         trigger_button_pin_oe_o <= 1'b0;
      end else begin
         if (!button_detect_select) begin
            button_armed            <= 1'b0;
            trigger_button_pin_o    <= 1'b0;
            trigger_button_pin_oe_o <= 1'b0;
         end else if (meas_cmd_i && start) begin
            button_armed            <= 1'b1;
            trigger_button_pin_o    <= 1'b0;
            trigger_button_pin_oe_o <= 1'b0;
         end else if (conv_end && button_armed) begin
            button_armed            <= 1'b0;
            trigger_button_pin_o    <= field_reached;
            trigger_button_pin_oe_o <= field_reached;
         end
      end
   end

   // assertion helper, busy cycles
   // Counts edges from start to end so the timer reload is checked whole
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_len     <= '0;
         conv_len_exp <= '0;
      end else if (start) begin
         conv_len     <= '0;
         conv_len_exp <= next_timer_load;
      end else if (conv_busy_o) begin
         conv_len     <= conv_len + 1'b1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_adc_sample_count: assert property (
      1 |=> adc_samples_o == 12'((2 ** $past(field_oversample_code))
            * ((2 ** $past(filter_depth_code)) + 2)))
      else $error("adc sample count wrong");

   a_filter_low_bits: assert property (
      (reg_we_i && cfg_sel) |=> filter_depth_code == $past(reg_wdata_i[2:0]))
      else $error("filter code not stored");

   a_osr_decode_value: assert property (
      1 |=> field_osr_samples_o == (12'h020 << $past(field_oversample_code))
         && thermal_osr_samples_o == (12'h020 << $past(cfg[12:11])))
      else $error("oversample decode wrong");

   a_pin_trig_start: assert property (
      (pin_rise && pin_trigger_enable && !button_detect_select
       && !conv_busy_o) |=> conv_busy_o)
      else $error("pin pulse did not start conversion");

   a_button_no_drive: assert property (
      $rose(trigger_button_pin_oe_o) |-> $past(conv_end)
         && $past(button_armed) && $past(button_detect_select))
      else $error("pin driven without command");

   a_button_field_gate: assert property (
      $rose(trigger_button_pin_o) |-> $past(field_reached)
         && trigger_button_pin_oe_o)
      else $error("pin driven below base value");

   a_conv_min_time: assert property (
      $rose(conv_busy_o) |-> conv_busy_o [*8] ##1 !conv_done_o)
      else $error("conversion ended too early");

   a_conv_exact_len: assert property (
      conv_done_o |-> conv_len == conv_len_exp)
      else $error("conversion length wrong");

   a_upper_bits_rw: assert property (
      (reg_we_i && cfg_sel) |=> cfg[15:13] == $past(reg_wdata_i[15:13]))
      else $error("upper bits not stored");

endmodule : hmc_top
`default_nettype wire

// ==== verification/hmc_host_model.sv ====
// Host side of the trigger/button pin: pulses it and resolves its level
`timescale 1ns/1ps
`default_nettype none
module hmc_host_model (
   input  wire logic clk_i,
   input  wire logic fire_i,
   input  wire logic dev_pin_i,
   input  wire logic dev_oe_i,
   output logic      pin_o
);
   logic [2:0] hold = 3'h0;
   always_ff @(posedge clk_i) hold <= fire_i ? 3'h4 : hold - 3'(hold != 3'h0);
   // Pull-down holds the line low when nobody drives it
   assign pin_o = dev_oe_i ? dev_pin_i : (hold != 3'h0);
endmodule : hmc_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the measurement config and trigger block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i = 0, rst_i = 1, we = 0, re = 0, cmd = 0, fire = 0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, field = 16'h0080, base = 16'h0080;
   logic [15:0] rdata;
   logic [11:0] adc, fosr, tosr;
   logic        pin, pin_o, pin_oe, busy, done;
   int          miscompares = 0, n_compared = 0;
   // every write keeps the gain field at six
   localparam logic [15:0] KEEP = 16'h0030;
   always #2.5 clk_i = ~clk_i;
   hmc_top #(.CYC_PER_US(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
      .reg_rdata_o(rdata), .meas_cmd_i(cmd), .plane_field_i(field),
      .base_value_i(base), .trigger_button_pin_i(pin),
      .trigger_button_pin_o(pin_o), .trigger_button_pin_oe_o(pin_oe),
      .conv_busy_o(busy), .conv_done_o(done), .adc_samples_o(adc),
      .field_osr_samples_o(fosr), .thermal_osr_samples_o(tosr));
   hmc_host_model u_host (.clk_i(clk_i), .fire_i(fire), .dev_pin_i(pin_o),
      .dev_oe_i(pin_oe), .pin_o(pin));
   task automatic chk(input logic [15:0] got, exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      addr = a; wdata = d; we = 1; cyc(1); we = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      addr = a; re = 1; cyc(1); re = 0; cyc(1);
      chk(rdata, e, "read");
   endtask
   // Cycles from the taking edge to the done pulse
   task automatic conv(input int e);
      int n;
      n = 0;
      cmd = 1; cyc(1); cmd = 0;
      while (done !== 1'b1 && n < 3000) begin
         cyc(1); n++;
      end
      chk(16'(n), 16'(e), "conv time");
   endtask
   task automatic pulse_pin;
      fire = 1; cyc(1); fire = 0; cyc(10);
   endtask
   task automatic t_reg;
      rd(8'h1C, 16'h0030);
      wr(8'h1C, 16'hE000 | KEEP); rd(8'h1C, 16'hE030);
      wr(8'h33, 16'h0000); rd(8'h33, 16'h0000); rd(8'h1C, 16'hE030);
      $display("test reg done");
   endtask
   task automatic t_osr;
      for (int f = 0; f < 8; f++) begin
         for (int o = 0; o < 4; o++) begin
            wr(8'h1C, KEEP | 16'(o << 9) | 16'((3 - o) << 11) | 16'(f));
            cyc(2);
            chk({4'h0, adc}, 16'((1 << o) * ((1 << f) + 2)), "adc");
            chk({4'h0, fosr}, 16'h0020 << o, "field osr");
            chk({4'h0, tosr}, 16'h0020 << (3 - o), "thermal osr");
         end
      end
      $display("test osr done");
   endtask
   task automatic t_conv;
      wr(8'h1C, KEEP); cyc(1); conv(3 + 69);
      wr(8'h1C, KEEP | 16'h0607); cyc(1); conv(8 * (128 + 2) + 69);
      $display("test conv done");
   endtask
   task automatic t_pin;
      wr(8'h1C, KEEP | 16'h0080); pulse_pin;
      chk(16'(busy), 16'h0001, "pin start");
      cyc(80);
      chk(16'(pin_oe), 16'h0000, "pin idle");
      $display("test pin done");
   endtask
   task automatic t_button;
      wr(8'h1C, KEEP | 16'h0180); pulse_pin;
      chk({15'h0, busy | pin_oe}, 16'h0000, "button quiet");
      conv(3 + 69); cyc(1);
      chk({14'h0, pin_oe, pin_o}, 16'h0003, "button hit");
      field = 16'h007F; conv(3 + 69); cyc(1);
      chk(16'(pin_oe), 16'h0000, "button miss");
      $display("test button done");
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      cyc(2); rst_i = 0;
      t_reg; t_osr; t_conv; t_pin; t_button;
      print_verdict;
   end
   // Tests need under 3000 cycles; far longer means a hang
   initial begin
      #200000; miscompares++; print_verdict;
   end
endmodule : tb
`default_nettype wire
